// [verilog/reset_and_test_strap_sampler.sv]
// Power-on reset handling and test-strap sampling
`timescale 1ns/1ps
`default_nettype none
module reset_and_test_strap_sampler #(
   parameter int SAMPLE_CYCLES = strap_pkg::SAMPLE_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       scan_port_reset_n,
   input  wire logic [7:0] strap_in,
   input  wire logic [7:0] test_data,
   output var  logic [7:0] strap_out,
   output var  logic [7:0] strap_oe_n,
   output var  logic [7:0] test_mode_select,
   output var  logic       test_mode_active,
   output var  logic       config_start,
   output var  logic       controller_reset_n,
   output var  logic       scan_reset_seen
);
   import strap_pkg::*;

   // ==========================================
   // Reset release
   // Async assert, sync release; whole controller held while pin low
   logic [1:0] reset_pipe;
   logic       reset_int_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_pipe <= 2'b00;
      end else begin
         reset_pipe <= {reset_pipe[0], 1'b1};
      end
   end
   assign reset_int_n = reset_pipe[1];

   // ==========================================
   // Strap and scan reset synchronisers
   logic [7:0] strap_sync_q;
   strap_sync #(.WIDTH(STRAP_WIDTH)) u_sync (
      .clock    (clock),
      .reset_n  (reset_int_n),
      .async_in (strap_in),
      .sync_out (strap_sync_q)
   );

   logic [1:0] scan_pipe;
   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         scan_pipe <= 2'b00;
      end else begin
         scan_pipe <= {scan_pipe[0], scan_port_reset_n};
      end
   end

   // Flag only: the far side must keep this low, we just report a violation
   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         scan_reset_seen <= 1'b0;
      end else if (scan_pipe[1]) begin
         scan_reset_seen <= 1'b1;
      end
   end

   // ==========================================
   // Sequencer
   seq_state_type          state;
   logic [COUNT_WIDTH-1:0] count;
   logic                   sample_now;

   // Synchroniser latency is inside the delay budget, so the sample sees pins as at about 1.3 us
   assign sample_now = (state == st_wait_sample) && (count == COUNT_WIDTH'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         state <= st_wait_sample;
         count <= '0;
      end else begin
         case (state)
            st_wait_sample: begin
               if (sample_now) begin
                  state <= st_drive;
               end else begin
                  count <= count + COUNT_WIDTH'(1);
               end
            end
            st_drive: begin
               state <= st_drive;
            end
            default: begin
               state <= st_wait_sample;
            end
         endcase
      end
   end

   // Self-configuration kick, one pulse on the first cycle after release
   logic started;
   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         started      <= 1'b0;
         config_start <= 1'b0;
      end else begin
         started      <= 1'b1;
         config_start <= !started;
      end
   end

   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         controller_reset_n <= 1'b0;
      end else begin
         controller_reset_n <= 1'b1;
      end
   end

   // ==========================================
   // Latched test-mode selection
   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         test_mode_select <= STRAP_RESET;
         test_mode_active <= 1'b0;
      end else if (sample_now) begin
         test_mode_select <= strap_sync_q;
         test_mode_active <= |strap_sync_q;
      end
   end

   // ==========================================
   // Pin turnaround
   always_ff @(posedge clock or negedge reset_int_n) begin
      if (!reset_int_n) begin
         strap_oe_n <= 8'hff;
         strap_out  <= TEST_OUT_RESET;
      end else if (state == st_drive || sample_now) begin
         strap_oe_n <= 8'h00;
         strap_out  <= test_data;
      end
   end

   // ==========================================
   // Checks
   // All checks drop out with the internal reset, so a mid-run power cycle never trips them
   chk_float_during_wait: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_wait_sample) |-> (strap_oe_n == 8'hff))
      else $error("strap pins driven before sample");

   chk_drive_after_sample: assert property (@(posedge clock) disable iff (!reset_int_n)
      sample_now |=> (strap_oe_n == 8'h00) && (state == st_drive))
      else $error("strap pins not driven after sample");

   chk_sample_capture: assert property (@(posedge clock) disable iff (!reset_int_n)
      sample_now |=> (test_mode_select == $past(strap_sync_q)))
      else $error("strap sample not captured");

   chk_select_stable: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |=> $stable(test_mode_select))
      else $error("test mode selection changed");

   chk_test_mode_flag: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |-> (test_mode_active == (|test_mode_select)))
      else $error("test mode flag mismatch");

   chk_config_pulse: assert property (@(posedge clock) disable iff (!reset_int_n)
      config_start |=> !config_start && controller_reset_n)
      else $error("config start not a single pulse");

   chk_controller_released: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |-> controller_reset_n)
      else $error("controller still in reset");

   chk_quiet_until_start: assert property (@(posedge clock) disable iff (!reset_int_n)
      !started |-> !config_start && !test_mode_active)
      else $error("output active before start");

   chk_scan_flag: assert property (@(posedge clock) disable iff (!reset_int_n)
      scan_pipe[1] |=> scan_reset_seen)
      else $error("scan reset violation not flagged");

   // ==========================================
   // Pin, sequencer, selection, controller-reset and scan-flag invariants
   // The pins turn around as one group; a split enable would fight the pull resistors
   chk_float_until_start: assert property (@(posedge clock) disable iff (!reset_int_n)
      !started |-> (strap_oe_n == 8'hff))
      else $error("strap pins driven at release");

   chk_oe_uniform: assert property (@(posedge clock) disable iff (!reset_int_n)
      (strap_oe_n == 8'hff) || (strap_oe_n == 8'h00))
      else $error("strap enables split");

   chk_out_quiet_wait: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_wait_sample) |-> (strap_out == TEST_OUT_RESET))
      else $error("test output active before sample");

   chk_out_follows_data: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |=> (strap_out == $past(test_data)))
      else $error("test output not following data");

   chk_count_bounded: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_wait_sample) |-> (count <= COUNT_WIDTH'(SAMPLE_CYCLES - 1)))
      else $error("sample counter overran");

   chk_count_advance: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_wait_sample) && !sample_now |=> (count == $past(count) + COUNT_WIDTH'(1)))
      else $error("sample counter stalled");

   chk_drive_holds: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |=> (state == st_drive))
      else $error("sequencer left drive state");

   chk_single_sample: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_drive) |-> !sample_now)
      else $error("strap pins sampled twice");

   chk_select_clear_wait: assert property (@(posedge clock) disable iff (!reset_int_n)
      (state == st_wait_sample) |-> (test_mode_select == STRAP_RESET) && !test_mode_active)
      else $error("selection set before sample");

   chk_controller_held: assert property (@(posedge clock) disable iff (!reset_int_n)
      !started |-> !controller_reset_n)
      else $error("controller released too early");

   chk_scan_flag_sticky: assert property (@(posedge clock) disable iff (!reset_int_n)
      scan_reset_seen |=> scan_reset_seen)
      else $error("scan reset flag lost");
endmodule
`default_nettype wire

// [verilog/strap_pkg.sv]
// Constants for the reset and test-strap sampler
`default_nettype none
package strap_pkg;
   // ==========================================
   // Timing
   localparam int   CLOCK_PERIOD_PS   = 100000;
   localparam int   SAMPLE_DELAY_PS   = 1500000;
   localparam int   SAMPLE_CYCLES     = (SAMPLE_DELAY_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int   COUNT_WIDTH       = 5;
   localparam int   STRAP_WIDTH       = 8;
   // ==========================================
   // Reset values
   localparam logic [7:0] STRAP_RESET = 8'h00;
   localparam logic [7:0] TEST_OUT_RESET = 8'h00;
   // ==========================================
   // Sequencer states
   typedef enum logic [1:0] {
      st_wait_sample = 2'b00,
      st_drive       = 2'b01
   } seq_state_type;
endpackage
`default_nettype wire

// [verilog/strap_sync.sv]
// Two-flip-flop synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage    <= '0;
         sync_out <= '0;
      end else begin
         stage    <= async_in;
         sync_out <= stage;
      end
   end
endmodule
`default_nettype wire

// [verification/pmic_model.sv]
// Power-management model driving the power-on and scan-port resets
`timescale 1ns/1ps
`default_nettype none
module pmic_model (
   input  wire logic clock,
   input  wire logic power_good,
   input  wire logic scan_fault,
   output var  logic rst_n,
   output var  logic scan_port_reset_n
);
   logic [1:0] settle;
   // ==========================================
   // Release only once supplies have been good for two cycles
   always_ff @(negedge clock or negedge power_good) begin
      if (!power_good) begin
         settle <= 2'h0;
         rst_n  <= 1'b0;
      end else begin
         settle <= {settle[0], 1'b1};
         rst_n  <= settle[1];
      end
   end
   // ==========================================
   // Scan-port reset stays low unless a fault is commanded
   always_comb begin
      scan_port_reset_n = scan_fault;
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Testbench for the reset and test-strap sampler
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int N = 3;
   logic       clock, power_good, scan_fault, rst_n, scan_port_reset_n;
   logic       test_mode_active, config_start, controller_reset_n, scan_reset_seen;
   logic [7:0] pull, test_data, strap_in, strap_out, strap_oe_n, test_mode_select;
   int         err_count, n_compared;
   // ==========================================
   // Pin level: design where enabled, else pull-up or the weak pulldown
   assign strap_in = (~strap_oe_n & strap_out) | (strap_oe_n & pull);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   pmic_model pm (.clock(clock), .power_good(power_good), .scan_fault(scan_fault), .rst_n(rst_n),
                  .scan_port_reset_n(scan_port_reset_n));
   reset_and_test_strap_sampler #(.SAMPLE_CYCLES(N)) dut (.clock(clock), .rst_n(rst_n),
      .scan_port_reset_n(scan_port_reset_n), .strap_in(strap_in), .test_data(test_data),
      .strap_out(strap_out), .strap_oe_n(strap_oe_n), .test_mode_select(test_mode_select),
      .test_mode_active(test_mode_active), .config_start(config_start),
      .controller_reset_n(controller_reset_n), .scan_reset_seen(scan_reset_seen));
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic end_sim;
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // One power cycle with the given strap levels
   task automatic boot(input logic [7:0] straps);
      int k;
      @(negedge clock);
      // Non-blocking so the model's falling-edge process never races the supply change
      power_good <= 1'b0;
      pull = straps;
      test_data = ~straps;
      repeat (10) @(negedge clock);
      check(strap_oe_n === 8'hff, "pins not floating");
      check(controller_reset_n === 1'b0, "controller not held");
      check(config_start === 1'b0 && strap_out === 8'h00, "output active in reset");
      check(test_mode_select === 8'h00 && test_mode_active === 1'b0, "selection not cleared");
      power_good <= 1'b1;
      k = 0;
      while (config_start !== 1'b1 && k < 20) begin
         @(negedge clock);
         k++;
      end
      check(config_start === 1'b1 && controller_reset_n === 1'b1, "no start pulse");
      check(strap_oe_n === 8'hff, "pins driven before sample");
      @(negedge clock);
      check(config_start === 1'b0, "start pulse too long");
      k = 1;
      while (strap_oe_n !== 8'h00 && k < 20) begin
         @(negedge clock);
         k++;
      end
      check(k == N - 1, "sample delay");
      check(test_mode_select === straps && test_mode_active === (|straps), "select");
      check(strap_out === ~straps, "test output");
      // Straps move after the sample; the selection must not follow, even past the synchroniser
      pull = ~straps;
      test_data = straps;
      @(negedge clock);
      check(strap_out === straps && strap_oe_n === 8'h00, "output follow");
      repeat (3) @(negedge clock);
      check(test_mode_select === straps && test_mode_active === (|straps), "select moved");
   endtask
   task automatic scan_check;
      check(scan_reset_seen === 1'b0, "flag early");
      scan_fault = 1'b1;
      repeat (4) @(negedge clock);
      scan_fault = 1'b0;
      check(scan_reset_seen === 1'b1 && test_mode_select === 8'h80, "scan flag");
      repeat (3) @(negedge clock);
      check(scan_reset_seen === 1'b1 && test_mode_active === 1'b1, "flag not sticky");
   endtask
   initial begin
      power_good = 1'b0;
      scan_fault = 1'b0;
      pull = 8'h00;
      test_data = 8'h00;
      boot(8'ha5);
      boot(8'h00);
      boot(8'h80);
      scan_check();
      end_sim();
   end
   // Boots take under 100 cycles; this limit leaves a wide margin
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
endmodule
`default_nettype wire
